// ---- verilog/bld_cfg_regs.sv ----
// Functional notes
// [RL1] hot current reduction enable, resets on
// [RL2] dimming mode field, mix/pwm/analog, resets 00
// [RL3] blend transfer point 25% or 12.5%
// [RL4] blend output frequency 200Hz or 23kHz
// [RL5] spread modulation rate 1/100, 1/150, 1/200
// [RL6] spread code 11 disables spreading, reset value
// [RL7] spread jitter range 1/20 or 1/32
// [RL8] phase offset enable bit, resets 0
// [RL9] short level 2.5/5/7.5/10V, resets 01
// [RL10] converter frequency 200k/400k/1M/2.2M, resets 01
// [RL11] string count code removes highest strings
// [RL12] string codes 110, 111 reserved
// [RL13] all-short guard armed only when enabled
// [RL14] ground short wait 20ms or 40ms
// [RL15] six fault flags at bits 5..0
// [RL16] fault flags sticky until read
// [RL17] reading fault register clears flags
// [RL18] fault pin low, released 750us after recovery
// [RL19] answer serial address 0x38, then index
// [RL20] fixed identifier, writes ignored
// [RL21] unmapped indexes read zero, writes dropped
`timescale 1ns/1ps
`default_nettype none
module bld_cfg_regs #(
	parameter int FF_HOLD_CYC = bld_pkg::FF_RELEASE_CYC,
	parameter logic [7:0] PART_ID = bld_pkg::PART_ID_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_q,
	output logic sda_oe_q,
	input wire logic [5:0] fault_in,
	output logic fault_indicator_out_q,
	output logic fault_indicator_oe_q,
	output logic hot_current_reduce_en_q,
	output logic [1:0] dim_mode_q,
	output logic blend_transfer_point_q,
	output logic blend_output_rate_resistor_pin_sel_q,
	output logic [1:0] spread_mod_rate_q,
	output logic spread_en_q,
	output logic spread_jitter_range_q,
	output logic phase_offset_en_q,
	output logic [1:0] short_level_sel_q,
	output logic [1:0] converter_rate_resistor_pin_sel_q,
	output logic [2:0] active_string_count_q,
	output logic [5:0] string_en_q,
	output logic all_short_guard_en_q,
	output logic ground_short_wait_sel_q,
	output logic [5:0] flags_q
);
	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// string count code to per-string enable; reserved codes keep string one only
	function automatic logic [5:0] bld_string_dec(input logic [2:0] code);
		logic [5:0] en;
		en = 6'h01;
		if (code <= bld_pkg::COUNT_LAST_LEGAL) // RL11 RL12
		begin
			en = 6'h3F >> code;
		end
		return en;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling; inputs are synchronous, one stage gives edge history

	logic scl_q, sda_q, scl_p_q, sda_p_q;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_q & ~scl_p_q;
	assign scl_fall = ~scl_q & scl_p_q;
	assign bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign bus_stop = scl_q & scl_p_q & ~sda_p_q & sda_q;

	////////////////////////////////////////////////////////////////////////////////
	// read data multiplexer

	logic [7:0] fset_one, fset_two, fault_reg, rd_data;
	assign fset_one = {hot_current_reduce_en_q, dim_mode_q, blend_transfer_point_q,
		blend_output_rate_resistor_pin_sel_q, spread_mod_rate_q, spread_jitter_range_q};
	assign fset_two = {phase_offset_en_q, short_level_sel_q, converter_rate_resistor_pin_sel_q,
		active_string_count_q};
	assign fault_reg = {all_short_guard_en_q, ground_short_wait_sel_q, flags_q};

	logic [7:0] ptr_q, ptr_d;
	always_comb
	begin
		unique case (ptr_q)
			bld_pkg::IDX_FUNC_ONE: rd_data = fset_one;
			bld_pkg::IDX_FUNC_TWO: rd_data = fset_two;
			bld_pkg::IDX_FAULT: rd_data = fault_reg;
			bld_pkg::IDX_IDENT: rd_data = PART_ID; // RL20
			default: rd_data = 8'h00; // RL21
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial slave state machine; the index auto-increments after each data byte

	bld_pkg::bld_state_e st_q, st_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] cnt_q, cnt_d;
	logic rw_q, rw_d, nack_q, nack_d, oe_d;
	logic wr_stb, load_rd;
	logic [5:0] flag_clr;

	always_comb
	begin
		st_d = st_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = sda_oe_q;
		ptr_d = ptr_q;
		wr_stb = 1'b0;
		load_rd = 1'b0;
		unique case (st_q)
			bld_pkg::ST_IDLE: ;
			bld_pkg::ST_ADDR, bld_pkg::ST_IDX, bld_pkg::ST_WDAT:
			begin
				if (scl_rise)
				begin
					shift_d = {shift_q[6:0], sda_q};
					cnt_d = cnt_q + 4'h1;
				end
				else if (scl_fall && cnt_q == 4'h8)
				begin
					cnt_d = 4'h0;
					if (st_q == bld_pkg::ST_ADDR)
					begin
						if (shift_q[7:1] == bld_pkg::DEV_ADDR) // RL19
						begin
							oe_d = 1'b1;
							rw_d = shift_q[0];
							st_d = bld_pkg::ST_AACK;
						end
						else
						begin
							st_d = bld_pkg::ST_IDLE;
						end
					end
					else
					begin
						oe_d = 1'b1;
						st_d = bld_pkg::ST_DACK;
						if (st_q == bld_pkg::ST_IDX)
						begin
							ptr_d = shift_q; // RL19
						end
						else
						begin
							wr_stb = 1'b1;
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
			end
			bld_pkg::ST_AACK:
			begin
				if (scl_fall)
				begin
					if (rw_q)
					begin
						load_rd = 1'b1;
					end
					else
					begin
						oe_d = 1'b0;
						st_d = bld_pkg::ST_IDX;
					end
				end
			end
			bld_pkg::ST_DACK:
			begin
				if (scl_fall)
				begin
					oe_d = 1'b0;
					st_d = bld_pkg::ST_WDAT;
				end
			end
			bld_pkg::ST_RDAT:
			begin
				if (scl_fall)
				begin
					if (cnt_q == 4'h8)
					begin
						oe_d = 1'b0;
						st_d = bld_pkg::ST_RACK;
					end
					else
					begin
						shift_d = {shift_q[6:0], 1'b0};
						oe_d = ~shift_q[6];
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			bld_pkg::ST_RACK:
			begin
				if (scl_rise)
				begin
					nack_d = sda_q;
				end
				else if (scl_fall)
				begin
					if (nack_q)
					begin
						st_d = bld_pkg::ST_IDLE;
					end
					else
					begin
						load_rd = 1'b1;
					end
				end
			end
			default: st_d = bld_pkg::ST_IDLE;
		endcase
		// load the next byte and drive its first bit
		if (load_rd)
		begin
			shift_d = rd_data;
			oe_d = ~rd_data[7];
			cnt_d = 4'h1;
			ptr_d = ptr_q + 8'h01;
			st_d = bld_pkg::ST_RDAT;
		end
		// start or stop override any bit phase
		if (bus_start)
		begin
			st_d = bld_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end
		else if (bus_stop)
		begin
			st_d = bld_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
	end

	// flags that were just handed to the master are cleared by the read
	assign flag_clr = (load_rd && ptr_q == bld_pkg::IDX_FAULT) ? flags_q : 6'h00; // RL17

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q <= bld_pkg::ST_IDLE;
			shift_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sda_out_q <= 1'b0;
			ptr_q <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			sda_oe_q <= oe_d;
			sda_out_q <= 1'b0; // open drain: only ever pulls low
			ptr_q <= ptr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] one_d, two_d;
	logic [1:0] prot_d;
	always_comb
	begin
		one_d = fset_one;
		two_d = fset_two;
		prot_d = {all_short_guard_en_q, ground_short_wait_sel_q};
		if (wr_stb)
		begin
			unique case (ptr_q)
				bld_pkg::IDX_FUNC_ONE: one_d = shift_q; // RL1 RL2 RL3 RL4 RL5 RL7
				bld_pkg::IDX_FUNC_TWO: two_d = shift_q; // RL8 RL9 RL10 RL11
				bld_pkg::IDX_FAULT: prot_d = shift_q[bld_pkg::GUARD_POS:bld_pkg::WAIT_POS]; // RL13 RL14
				default: ; // RL20 RL21
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hot_current_reduce_en_q <= bld_pkg::RST_HOT; // RL1
			dim_mode_q <= bld_pkg::RST_MODE; // RL2
			blend_transfer_point_q <= bld_pkg::RST_TP; // RL3
			blend_output_rate_resistor_pin_sel_q <= bld_pkg::RST_BFREQ; // RL4
			spread_mod_rate_q <= bld_pkg::RST_SMR; // RL6
			spread_en_q <= 1'b0;
			spread_jitter_range_q <= bld_pkg::RST_SJR; // RL7
			phase_offset_en_q <= bld_pkg::RST_PHASE; // RL8
			short_level_sel_q <= bld_pkg::RST_SHORT; // RL9
			converter_rate_resistor_pin_sel_q <= bld_pkg::RST_CONV; // RL10
			active_string_count_q <= bld_pkg::RST_COUNT;
			string_en_q <= 6'h3F;
			all_short_guard_en_q <= bld_pkg::RST_GUARD; // RL13
			ground_short_wait_sel_q <= bld_pkg::RST_WAIT; // RL14
		end
		else
		begin
			hot_current_reduce_en_q <= one_d[bld_pkg::HOT_POS];
			dim_mode_q <= one_d[bld_pkg::MODE_LSB +: 2];
			blend_transfer_point_q <= one_d[bld_pkg::TP_POS];
			blend_output_rate_resistor_pin_sel_q <= one_d[bld_pkg::BFREQ_POS];
			spread_mod_rate_q <= one_d[bld_pkg::SMR_LSB +: 2]; // RL5
			spread_en_q <= (spread_mod_rate_q != bld_pkg::SMR_OFF); // RL6
			spread_jitter_range_q <= one_d[bld_pkg::SJR_POS];
			phase_offset_en_q <= two_d[bld_pkg::PHASE_POS];
			short_level_sel_q <= two_d[bld_pkg::SHORT_LSB +: 2];
			converter_rate_resistor_pin_sel_q <= two_d[bld_pkg::CONV_LSB +: 2];
			active_string_count_q <= two_d[bld_pkg::COUNT_LSB +: 3];
			string_en_q <= bld_string_dec(active_string_count_q); // RL11
			all_short_guard_en_q <= prot_d[1];
			ground_short_wait_sel_q <= prot_d[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault flags and fault indicator; a new fault beats a same-cycle clear

	logic [5:0] flags_d;
	logic [16:0] hold_q, hold_d;
	logic ind_oe_d;
	always_comb
	begin
		flags_d = (flags_q & ~flag_clr) | fault_in; // RL15 RL16 RL17
		hold_d = hold_q;
		if (fault_in != 6'h00)
		begin
			hold_d = 17'(FF_HOLD_CYC); // RL18
		end
		else if (hold_q != 17'h00000)
		begin
			hold_d = hold_q - 17'h00001;
		end
		ind_oe_d = (hold_d != 17'h00000); // RL18
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			flags_q <= bld_pkg::RST_FLAGS;
			hold_q <= 17'h00000;
			fault_indicator_oe_q <= 1'b0;
			fault_indicator_out_q <= 1'b0;
		end
		else
		begin
			flags_q <= flags_d;
			hold_q <= hold_d;
			fault_indicator_oe_q <= ind_oe_d;
			fault_indicator_out_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_fault_pin_low: assert property (@(posedge sys_clk) disable iff (!rstn) // RL18
		fault_in != 6'h00 |=> fault_indicator_oe_q)
		else $error("fault pin not pulled low");
	chk_fault_pin_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // RL18
		$fell(fault_in != 6'h00) |-> fault_indicator_oe_q [*2])
		else $error("fault pin released too early");
	chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // RL16
		1'b1 |=> (((($past(flags_q) & ~$past(flag_clr)) | $past(fault_in)) & ~flags_q) == 6'h00))
		else $error("fault flag lost");
	chk_flag_read_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // RL17
		(flag_clr != 6'h00 && fault_in == 6'h00) |=> (flags_q & $past(flag_clr)) == 6'h00)
		else $error("read did not clear flag");
	chk_spread_off: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
		spread_mod_rate_q == bld_pkg::SMR_OFF |=> !spread_en_q)
		else $error("spreading active with code 11");
	chk_all_strings: assert property (@(posedge sys_clk) disable iff (!rstn) // RL11
		active_string_count_q == 3'h0 |=> string_en_q == 6'h3F)
		else $error("code 000 must enable all strings");
	chk_addr_ack: assert property (@(posedge sys_clk) disable iff (!rstn) // RL19
		st_q == bld_pkg::ST_ADDR && st_d == bld_pkg::ST_AACK |-> shift_q[7:1] == bld_pkg::DEV_ADDR)
		else $error("acknowledged a foreign address");
	chk_mode_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
		wr_stb && ptr_q == bld_pkg::IDX_FUNC_ONE |=> dim_mode_q == $past(shift_q[6:5]))
		else $error("dimming mode write lost");
	chk_id_write_drop: assert property (@(posedge sys_clk) disable iff (!rstn) // RL20
		wr_stb && ptr_q >= bld_pkg::IDX_IDENT |=> $stable(fset_one) && $stable(fset_two))
		else $error("identifier write changed settings");
endmodule
`default_nettype wire

// ---- verilog/bld_pkg.sv ----
`default_nettype none
package bld_pkg;
	// serial link addressing
	localparam logic [6:0] DEV_ADDR = 7'h38;
	// register indexes
	localparam logic [7:0] IDX_FUNC_ONE = 8'h00;
	localparam logic [7:0] IDX_FUNC_TWO = 8'h01;
	localparam logic [7:0] IDX_FAULT = 8'h02;
	localparam logic [7:0] IDX_IDENT = 8'h03;
	// function_set_one field positions
	localparam int HOT_POS = 7;
	localparam int MODE_LSB = 5;
	localparam int TP_POS = 4;
	localparam int BFREQ_POS = 3;
	localparam int SMR_LSB = 1;
	localparam int SJR_POS = 0;
	// function_set_two field positions
	localparam int PHASE_POS = 7;
	localparam int SHORT_LSB = 5;
	localparam int CONV_LSB = 3;
	localparam int COUNT_LSB = 0;
	// fault_and_protection field positions
	localparam int GUARD_POS = 7;
	localparam int WAIT_POS = 6;
	localparam int FLAG_LSB = 0;
	// reset values
	localparam logic RST_HOT = 1'b1;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic RST_TP = 1'b0;
	localparam logic RST_BFREQ = 1'b0;
	localparam logic [1:0] RST_SMR = 2'h3;
	localparam logic RST_SJR = 1'b0;
	localparam logic RST_PHASE = 1'b0;
	localparam logic [1:0] RST_SHORT = 2'h1;
	localparam logic [1:0] RST_CONV = 2'h1;
	localparam logic [2:0] RST_COUNT = 3'h0;
	localparam logic RST_GUARD = 1'b0;
	localparam logic RST_WAIT = 1'b0;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	// encodings
	localparam logic [1:0] MODE_MIX = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h1;
	localparam logic [1:0] MODE_ANALOG = 2'h2;
	localparam logic [1:0] SMR_OFF = 2'h3;
	localparam logic [2:0] COUNT_LAST_LEGAL = 3'h5;
	// identifier value is arbitrary
	localparam logic [7:0] PART_ID_DEFAULT = 8'hA5;
	// fault indicator release delay
	localparam int CLK_MHZ = 100;
	localparam int FF_RELEASE_US = 750;
	localparam int FF_RELEASE_CYC = FF_RELEASE_US * CLK_MHZ;
	// fsm states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_AACK = 8'h04,
		ST_IDX = 8'h08,
		ST_WDAT = 8'h10,
		ST_DACK = 8'h20,
		ST_RDAT = 8'h40,
		ST_RACK = 8'h80
	} bld_state_e;
endpackage
`default_nettype wire

// ---- verif/bld_i2c_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// serial host model: scl stands high outside frames, released sda floats high
module bld_i2c_host (
	input wire logic sys_clk,
	input wire logic sda_dev_oe,
	output logic scl,
	output wire logic sda
);
	logic pull_q;
	// wired-and of both open-drain drivers against the bus pull-up
	assign sda = ~(pull_q | sda_dev_oe);
	initial
	begin
		scl = 1'b1;
		pull_q = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// start or repeated start; five-cycle phases keep clear of the four-cycle floor
	task automatic start_cond();
		pull_q = 1'b0;
		wt(3);
		scl = 1'b1;
		wt(5);
		pull_q = 1'b1;
		wt(5);
		scl = 1'b0;
	endtask
	task automatic stop_cond();
		pull_q = 1'b1;
		wt(3);
		scl = 1'b1;
		wt(5);
		pull_q = 1'b0;
		wt(5);
	endtask
	// data moves only while scl is low; sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		wt(2);
		pull_q = ~b;
		wt(3);
		scl = 1'b1;
		wt(3);
		r = sda;
		wt(2);
		scl = 1'b0;
	endtask
	// eight bits msb first, then the acknowledge slot (1 = released)
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
		output logic ack_out);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ack_in, a);
		ack_out = ~a;
	endtask
endmodule
`default_nettype wire

// ---- verif/backlight_driver_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module backlight_driver_config_regs_tb;
	localparam int HOLD = 20;
	localparam logic [7:0] ID = 8'h5C; // arbitrary identifier value
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] fault_in = 6'h00;
	logic scl, sda, sda_oe, sda_out, ff_out, ff_oe, hot, tp, bf, all_short_guard_en, sjr, ph, guard, wsel, ack;
	logic [1:0] mode, smr, shl, conv;
	logic [2:0] cnt;
	logic [5:0] sten, flags;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	bld_cfg_regs #(.FF_HOLD_CYC(HOLD), .PART_ID(ID)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.scl_in(scl), .sda_in(sda), .sda_out_q(sda_out), .sda_oe_q(sda_oe),
		.fault_in(fault_in), .fault_indicator_out_q(ff_out), .fault_indicator_oe_q(ff_oe),
		.hot_current_reduce_en_q(hot), .dim_mode_q(mode), .blend_transfer_point_q(tp),
		.blend_output_rate_resistor_pin_sel_q(bf), .spread_mod_rate_q(smr), .spread_en_q(all_short_guard_en),
		.spread_jitter_range_q(sjr), .phase_offset_en_q(ph), .short_level_sel_q(shl),
		.converter_rate_resistor_pin_sel_q(conv), .active_string_count_q(cnt), .string_en_q(sten),
		.all_short_guard_en_q(guard), .ground_short_wait_sel_q(wsel), .flags_q(flags));
	bld_i2c_host host (.sys_clk(sys_clk), .sda_dev_oe(sda_oe), .scl(scl), .sda(sda));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
			err_total++;
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_byte({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic reg_wr(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] junk;
		logic a;
		host.start_cond();
		host.byte_io({adr, 1'b0}, 1'b1, junk, a);
		chk_bit(a, adr == bld_pkg::DEV_ADDR, "address ack");
		host.byte_io(idx, 1'b1, junk, a);
		host.byte_io(d, 1'b1, junk, a);
		host.stop_cond();
	endtask
	// index set by a write frame, then repeated start and one byte closed by nack
	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] v);
		logic [7:0] junk;
		logic a;
		host.start_cond();
		host.byte_io({bld_pkg::DEV_ADDR, 1'b0}, 1'b1, junk, a);
		host.byte_io(idx, 1'b1, junk, a);
		host.start_cond();
		host.byte_io({bld_pkg::DEV_ADDR, 1'b1}, 1'b1, junk, a);
		host.byte_io(8'hFF, 1'b1, v, a);
		host.stop_cond();
	endtask
	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under half of this
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_total++;
			$display("MISMATCH t=%0t run did not finish", $time);
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [7:0] v, r;
		logic [7:0] rst_val [5];
		rst_val = '{8'h86, 8'h28, 8'h00, ID, 8'h00};
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (5) @(negedge sys_clk);
		chk_byte({2'h0, sten}, 8'h3F, "string enables at reset");
		chk_bit(sda_out, 1'b0, "data pin level");
		chk_bit(all_short_guard_en, 1'b0, "spread off at reset");
		for (int i = 0; i < 5; i++)
		begin
			reg_rd(i[7:0], r);
			chk_byte(r, rst_val[i], "reset value");
		end
		$display("test reset values done");
		// every mode and spread code, other bits toggled alongside
		for (int k = 0; k < 4; k++)
		begin
			v = {~k[0], k[1:0], k[0], k[1], k[1:0], k[0]};
			reg_wr(bld_pkg::DEV_ADDR, 8'h00, v);
			chk_byte({hot, mode, tp, bf, smr, sjr}, v, "reg0 fields");
			chk_bit(all_short_guard_en, k != 3, "spread enable");
			reg_rd(8'h00, r);
			chk_byte(r, v, "reg0 readback");
		end
		// every string code including the reserved ones
		for (int j = 0; j < 8; j++)
		begin
			v = {j[0], j[1:0], j[2:1], j[2:0]};
			reg_wr(bld_pkg::DEV_ADDR, 8'h01, v);
			chk_byte({ph, shl, conv, cnt}, v, "reg1 fields");
			chk_byte({2'h0, sten}, {2'h0, (j < 6) ? (6'h3F >> j) : 6'h01}, "strings");
		end
		$display("test field writes done");
		// foreign address, identifier and unmapped index must all leave state alone
		reg_wr(7'h39, 8'h00, 8'h00);
		reg_rd(8'h00, r);
		chk_byte(r, 8'h7F, "foreign address wrote");
		reg_wr(bld_pkg::DEV_ADDR, 8'h03, 8'h5A);
		reg_rd(8'h03, r);
		chk_byte(r, ID, "identifier");
		reg_wr(bld_pkg::DEV_ADDR, 8'h07, 8'hFF);
		reg_rd(8'h07, r);
		chk_byte(r, 8'h00, "unmapped");
		$display("test refusals done");
		// flag bits cannot be written; only the two controls take
		reg_wr(bld_pkg::DEV_ADDR, 8'h02, 8'hFF);
		chk_byte({guard, wsel, flags}, 8'hC0, "reg2 write");
		for (int i = 0; i < 6; i++)
		begin
			fault_in = 6'h01 << i;
			repeat (3) @(negedge sys_clk);
			fault_in = 6'h00;
			chk_byte({2'h0, flags}, {2'h0, 6'h01 << i}, "flag set");
			chk_bit(ff_oe, 1'b1, "fault pin pulled");
			chk_bit(ff_out, 1'b0, "fault pin level");
			repeat (HOLD - 1) @(negedge sys_clk);
			chk_bit(ff_oe, 1'b1, "fault pin early release");
			repeat (1) @(negedge sys_clk);
			chk_bit(ff_oe, 1'b0, "fault pin held");
			chk_byte({2'h0, flags}, {2'h0, 6'h01 << i}, "flag sticky");
			reg_rd(8'h02, r);
			chk_byte(r, {2'h3, 6'h01 << i}, "flag read");
			chk_byte({2'h0, flags}, 8'h00, "flag cleared");
			reg_rd(8'h02, r);
			chk_byte(r, 8'hC0, "flag read twice");
		end
		// a condition still present during the read keeps its flag
		fault_in = 6'h04;
		repeat (2) @(negedge sys_clk);
		reg_rd(8'h02, r);
		chk_byte(r, 8'hC4, "live fault read");
		fault_in = 6'h00;
		repeat (30) @(negedge sys_clk);
		chk_byte({2'h0, flags}, 8'h04, "live fault kept");
		reg_rd(8'h02, r);
		chk_byte(r, 8'hC4, "kept flag read");
		reg_rd(8'h02, r);
		chk_byte(r, 8'hC0, "cleared after read");
		$display("test fault flags done");
		wrap_up();
	end
endmodule
`default_nettype wire
